/* File: acs_sequencer.v */
// conversion sequencer for a 10-bit eight-channel successive-approximation converter
//
// Chosen here: the strobed register port and the register addresses.
`timescale 1ns/1ns
`include "acs_consts.vh"
module acs_sequencer (
   input  wire        sys_clk_i,    // system clock, 125 MHz
   input  wire        arst_n_i,     // async reset, active low
   input  wire [7:0]  addr_i,       // register address
   input  wire [7:0]  wdata_i,      // write data
   input  wire        wr_i,         // write strobe
   input  wire        rd_i,         // read strobe
   output reg  [7:0]  rdata_o,      // read data, cycle after strobe
   input  wire        ext_start_i,  // external start pin
   input  wire [7:0]  ain_dig_i,    // channel pins as digital inputs
   input  wire [9:0]  sample_i,     // converter core result
   output reg  [7:0]  chan_sel_o,   // one-hot channel mux select
   output reg         sample_o,     // converter core capture pulse
   output wire        done_irq_o    // done flag level
);
   // =====================================================
   // state and decoding
   // =====================================================
   localparam ST_IDLE = 2'b01;
   localparam ST_CONV = 2'b10;

   reg  [1:0]  state_ff;
   reg  [7:0]  div_ff;
   reg  [7:0]  conv_cnt_ff;
   reg         pin_prev_ff;
   reg         ever_conv_ff;
   reg         ext_cont_ff;
   reg         ext_en_ff;
   reg         cont_ff;
   reg  [2:0]  mx_ff;
   reg  [9:0]  res_ff;
   reg         done_ff;
   reg  [7:0]  hold_ff;
   reg  [7:0]  din_ff;
   wire        pin_lvl;
   wire        mcyc_en;
   wire        smp_en;
   wire        wr_low;
   wire        fall;
   wire        finish;
   wire        restart;
   reg         start;
   reg  [7:0]  nxt_hold;
   wire [7:0]  ain_lvl;
   wire        ext_cont_go;
   wire        busy;
   wire        wr_ctrl_a;
   wire        wr_ctrl_b;
   wire        wr_irq;
   genvar      g;

   function [7:0] onehot8;
      input [2:0] idx;
      begin
         onehot8 = 8'h01 << idx;
      end
   endfunction

   function hit;
      input [7:0] a;
      input [7:0] off;
      begin
         hit = (a == off);
      end
   endfunction

   acs_pin_sync u_sync (
      .sys_clk_i (sys_clk_i),
      .arst_n_i  (arst_n_i),
      .pin_i     (ext_start_i),
      .level_o   (pin_lvl)
   );

   // =====================================================
   // channel pin synchronisers
   // =====================================================
   // channel pins are asynchronous too, so each gets the start pin's filter
   generate
      for (g = 0; g < `ACS_NUM_CHAN; g = g + 1) begin : g_ain_sync
         acs_pin_sync u_ain_sync (
            .sys_clk_i (sys_clk_i),
            .arst_n_i  (arst_n_i),
            .pin_i     (ain_dig_i[g]),
            .level_o   (ain_lvl[g])
         );
      end
   endgenerate

   // =====================================================
   // machine cycle divider
   // =====================================================
   always @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         div_ff <= 8'h00;
      end else if (div_ff == `ACS_MCYC_LAST) begin
         div_ff <= 8'h00;
      end else begin
         div_ff <= div_ff + 8'h01;
      end
   end
   assign mcyc_en = (div_ff == `ACS_MCYC_LAST);
   assign smp_en  = (div_ff == `ACS_SAMPLE_PHASE); // state5_phase2 sample point

   // =====================================================
   // start logic
   // =====================================================
   assign wr_low  = wr_i && hit(addr_i, `ACS_OFF_RES_LOW);
   assign fall    = smp_en && pin_prev_ff && !pin_lvl;
   assign finish  = (state_ff == ST_CONV) && mcyc_en && (conv_cnt_ff == `ACS_CONV_MCYC - 8'h01);
   // software clearing continuous in the same cycle as finish still restarts once, since restart uses the old cont_ff
   assign restart = finish && cont_ff && (!ext_en_ff || (ext_cont_ff && !pin_lvl));
   // low pin keeps converting, but only after a falling edge or once a conversion has happened since reset
   assign ext_cont_go = ext_en_ff && cont_ff && smp_en && !pin_lvl && (ever_conv_ff || fall);

   always @* begin
      start = 1'b0;
      if (wr_low) begin
         start = 1'b1;
      end else if (ext_en_ff && !cont_ff && fall) begin
         start = 1'b1;
      end else if (ext_cont_go) begin
         start = 1'b1;
      end
   end

   always @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         state_ff     <= ST_IDLE;
         conv_cnt_ff  <= 8'h00;
         pin_prev_ff  <= 1'b1;
         ever_conv_ff <= 1'b0;
         ext_cont_ff  <= 1'b0;
         sample_o     <= 1'b0;
         res_ff       <= 10'h000;
      end else begin
         sample_o <= 1'b0;
         if (smp_en) begin
            pin_prev_ff <= pin_lvl;
         end
         if (ext_cont_go) begin
            ext_cont_ff <= 1'b1;
         end else if (pin_lvl) begin
            ext_cont_ff <= 1'b0;
         end
         case (state_ff)
            ST_IDLE: begin
               if (start) begin
                  state_ff    <= ST_CONV;
                  conv_cnt_ff <= 8'h00;
               end
            end
            ST_CONV: begin
               if (mcyc_en) begin
                  conv_cnt_ff <= conv_cnt_ff + 8'h01;
               end
               if (finish) begin
                  sample_o     <= 1'b1;
                  res_ff       <= sample_i;
                  ever_conv_ff <= 1'b1;
                  conv_cnt_ff  <= 8'h00;
                  if (!restart) begin
                     state_ff <= ST_IDLE;
                  end
               end
            end
            default: begin
               state_ff <= ST_IDLE;
            end
         endcase
      end
   end

   // =====================================================
   // register write decode
   // =====================================================
   assign wr_ctrl_a = wr_i && hit(addr_i, `ACS_OFF_CTRL_A);
   assign wr_ctrl_b = wr_i && hit(addr_i, `ACS_OFF_CTRL_B);
   assign wr_irq    = wr_i && hit(addr_i, `ACS_OFF_IRQ_REQ);
   // busy follows the state, so no separate flag can disagree with it
   assign busy      = (state_ff == ST_CONV);

   // =====================================================
   // control fields
   // =====================================================
   always @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         ext_en_ff <= 1'b0;
         cont_ff   <= 1'b0;
         mx_ff     <= 3'h0;
      end else begin
         if (wr_ctrl_a) begin
            ext_en_ff <= wdata_i[`ACS_BIT_EXT_EN];
            cont_ff   <= wdata_i[`ACS_BIT_CONT]; // busy bit ignored
            mx_ff     <= wdata_i[`ACS_MX_HI:`ACS_MX_LO];
         end
         // one stored field behind both registers, the later write wins
         if (wr_ctrl_b) begin
            mx_ff <= wdata_i[`ACS_MX_HI:`ACS_MX_LO];
         end
      end
   end

   // =====================================================
   // channel mux and pin snapshot
   // =====================================================
   // select is registered so the mux never sees a decode glitch
   always @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         chan_sel_o <= 8'h01;
         din_ff     <= 8'hFF;
      end else begin
         chan_sel_o <= onehot8(mx_ff);
         din_ff     <= ain_lvl;
      end
   end

   // =====================================================
   // done flag
   // =====================================================
   always @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         done_ff <= 1'b0;
      end else if (finish) begin
         // set wins over clear, so a completion is never lost to a racing write
         done_ff <= 1'b1;
      end else if (wr_irq) begin
         done_ff <= wdata_i[`ACS_BIT_DONE];
      end
   end

   // =====================================================
   // read data, valid in the cycle after the strobe only
   // =====================================================
   always @* begin
      nxt_hold = 8'h00;
      if (rd_i) begin
         case (addr_i)
            `ACS_OFF_RES_HIGH: begin
               nxt_hold = res_ff[`ACS_RES_W-1:`ACS_RES_HI_LSB];
            end
            // low byte shows only the two lowest result bits, at the top
            `ACS_OFF_RES_LOW: begin
               nxt_hold = {6'h00, res_ff[`ACS_RES_HI_LSB-1:0]} << `ACS_RES_LOW_SHIFT;
            end
            `ACS_OFF_CTRL_A: begin
               nxt_hold = {2'h0, ext_en_ff, busy, cont_ff, mx_ff};
            end
            `ACS_OFF_CTRL_B: begin
               nxt_hold = {5'h00, mx_ff};
            end
            `ACS_OFF_IRQ_REQ: begin
               nxt_hold = {7'h00, done_ff};
            end
            `ACS_OFF_PIN_IN: begin
               nxt_hold = din_ff;
            end
            // unmapped addresses read as zero
            default: begin
               nxt_hold = 8'h00;
            end
         endcase
      end
   end

   // zero outside read cycles, so stale data never lingers on the bus
   always @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         hold_ff <= 8'h00;
      end else begin
         hold_ff <= nxt_hold;
      end
   end

   always @* begin
      rdata_o = hold_ff;
   end

   assign done_irq_o = done_ff;
endmodule // acs_sequencer

/* File: acs_consts.vh */
// constants for the conversion sequencer
`ifndef ACS_CONSTS_VH
`define ACS_CONSTS_VH
// register offsets
`define ACS_OFF_RES_HIGH    8'hD9
`define ACS_OFF_RES_LOW     8'hDA
`define ACS_OFF_CTRL_A      8'hD8
`define ACS_OFF_CTRL_B      8'hDC
`define ACS_OFF_IRQ_REQ     8'hC0
`define ACS_OFF_PIN_IN      8'hE8
// control reg a fields
`define ACS_BIT_EXT_EN      5
`define ACS_BIT_BUSY        4
`define ACS_BIT_CONT        3
`define ACS_MX_HI           2
`define ACS_MX_LO           0
// irq request reg field
`define ACS_BIT_DONE        0
// result layout
`define ACS_RES_W           10
`define ACS_RES_LOW_SHIFT   6
`define ACS_RES_HI_LSB      2
// channel count
`define ACS_NUM_CHAN        8
// timing
`define ACS_MCYC_DIV        8'h0C
`define ACS_MCYC_LAST       8'h0B
`define ACS_SAMPLE_PHASE    8'h09
`define ACS_CONV_MCYC       8'h0A
`endif

/* File: acs_pin_sync.v */
// three-stage synchroniser with agreement filter for one pin
`timescale 1ns/1ns
module acs_pin_sync (
   input  wire sys_clk_i,  // system clock
   input  wire arst_n_i,   // async reset, active low
   input  wire pin_i,      // raw pin
   output wire level_o     // filtered level
);
   reg s1_ff;
   reg s2_ff;
   reg s3_ff;
   reg lvl_ff;
   always @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         s1_ff  <= 1'b1;
         s2_ff  <= 1'b1;
         s3_ff  <= 1'b1;
         lvl_ff <= 1'b1;
      end else begin
         s1_ff <= pin_i;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
         // only first stage is kept away from the filter
         if (s2_ff == s3_ff) begin
            lvl_ff <= s3_ff;
         end
      end
   end
   assign level_o = lvl_ff;
endmodule // acs_pin_sync

/* File: acs_sequencer_checker.sv */
// port assertions for the conversion sequencer
`timescale 1ns/1ns
`include "acs_consts.vh"
module acs_sequencer_checker (
   input wire       sys_clk_i,   // clock
   input wire       arst_n_i,    // reset, active low
   input wire [7:0] addr_i,      // address
   input wire [7:0] wdata_i,     // write data
   input wire       wr_i,        // write strobe
   input wire       rd_i,        // read strobe
   input wire [7:0] rdata_o,     // read data
   input wire [7:0] chan_sel_o,  // channel select
   input wire       sample_o,    // capture pulse
   input wire       done_irq_o   // done flag
);
   wire [2:0] wsel = wdata_i[2:0];
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!arst_n_i);
   // ================================================
   // properties
   property p_onehot; $onehot(chan_sel_o); endproperty
   a_onehot: assert property (p_onehot) else $error("channel select not one-hot");
   property p_rd_idle; !rd_i |=> rdata_o == 8'h00; endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data outside read cycle");
   property p_unmapped; rd_i && addr_i == 8'h00 |=> rdata_o == 8'h00; endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   // capture pulses never closer than nine clock cycles
   property p_gap; sample_o |=> (!sample_o) [*8]; endproperty
   a_gap: assert property (p_gap) else $error("capture pulses too close");
   property p_start; wr_i && addr_i == `ACS_OFF_RES_LOW |-> ##[1:125] sample_o; endproperty
   a_start: assert property (p_start) else $error("low byte write gave no conversion");
   property p_done; sample_o |-> ##[0:1] done_irq_o; endproperty
   a_done: assert property (p_done) else $error("done flag not set at finish");
   property p_rise;
      $rose(done_irq_o) |-> sample_o || $past(sample_o) || ($past(wr_i) && $past(addr_i) == `ACS_OFF_IRQ_REQ);
   endproperty
   a_rise: assert property (p_rise) else $error("done flag set without cause");
   property p_chan;
      wr_i && (addr_i == `ACS_OFF_CTRL_A || addr_i == `ACS_OFF_CTRL_B) ##1 !wr_i
         |=> chan_sel_o == (8'h01 << $past(wsel, 2));
   endproperty
   a_chan: assert property (p_chan) else $error("channel select not following field");
endmodule // acs_sequencer_checker
bind acs_sequencer acs_sequencer_checker i_acs_sequencer_checker (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i),
   .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .chan_sel_o(chan_sel_o),
   .sample_o(sample_o), .done_irq_o(done_irq_o));

/* File: acs_analog_model.sv */
// analog input model: one fixed level per channel
`timescale 1ns/1ns
module acs_analog_model (
   input  wire [7:0] chan_sel_i,  // one-hot select
   output reg  [9:0] level_o      // converted level
);
   integer k;
   always @* begin
      level_o = 10'h000;
      for (k = 0; k < 8; k = k + 1) if (chan_sel_i[k]) level_o = {k[2:0], 7'h2B};
   end
endmodule // acs_analog_model

/* File: acs_sequencer_tb.sv */
// self-checking bench for the conversion sequencer
`timescale 1ns/1ns
`include "acs_consts.vh"
module acs_sequencer_tb;
   reg        sys_clk_i, arst_n_i, wr_i, rd_i, ext_start_i;
   reg  [7:0] addr_i, wdata_i, ain_dig_i, d;
   reg  [9:0] k;
   wire [7:0] rdata_o, chan_sel_o;
   wire [9:0] sample_i;
   wire       sample_o, done_irq_o;
   integer    err_count, samples_checked, cyc;
   localparam [9:0] V5 = {3'h5, 7'h2B};
   acs_sequencer i_acs_sequencer (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
      .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .ext_start_i(ext_start_i), .ain_dig_i(ain_dig_i),
      .sample_i(sample_i), .chan_sel_o(chan_sel_o), .sample_o(sample_o), .done_irq_o(done_irq_o));
   acs_analog_model i_acs_analog_model (.chan_sel_i(chan_sel_o), .level_o(sample_i));
   initial begin
      sys_clk_i = 1'b0;
      forever #4 sys_clk_i = ~sys_clk_i;
   end
   always @(posedge sys_clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 6000) begin
         err_count = err_count + 1;
         final_report;
      end
   end
   // ================================================
   // bus and check tasks
   task wr(input [7:0] a, input [7:0] v);
      @(posedge sys_clk_i); addr_i <= a; wdata_i <= v; wr_i <= 1'b1;
      @(posedge sys_clk_i); wr_i <= 1'b0;
   endtask
   task rd(input [7:0] a);
      @(posedge sys_clk_i); addr_i <= a; rd_i <= 1'b1;
      @(posedge sys_clk_i); rd_i <= 1'b0;
      #1 d = rdata_o;
   endtask
   task chk(input [31:0] nm, input [9:0] e, input [9:0] g);
      samples_checked = samples_checked + 1;
      if (g !== e) begin
         err_count = err_count + 1;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask
   task cnt(input integer n);
      k = 0;
      repeat (n) begin
         @(posedge sys_clk_i);
         if (sample_o === 1'b1) k = k + 1;
      end
   endtask
   // bounded wait for the next capture pulse
   task wsmp;
      integer i;
      i = 0;
      do begin @(posedge sys_clk_i); i = i + 1; end while (sample_o !== 1'b1 && i < 200);
      chk("wait", 1, i < 200);
      k = i[9:0];
   endtask
   // ================================================
   // scenarios
   task t_extc;
      ext_start_i <= 1'b0;
      cnt(40);
      wr(`ACS_OFF_CTRL_A, 8'h28);
      cnt(300);
      chk("nolv", 0, k);
      ext_start_i <= 1'b1;
      cnt(40);
      ext_start_i <= 1'b0;
      wsmp;
      wsmp;
      ext_start_i <= 1'b1;
      cnt(300);
      chk("stop", 1, k);
      $display("extc done");
   endtask
   task t_single;
      wr(`ACS_OFF_IRQ_REQ, 8'h00);
      wr(`ACS_OFF_CTRL_A, 8'h05);
      wr(`ACS_OFF_RES_LOW, 8'h00);
      rd(`ACS_OFF_CTRL_A);
      chk("bsy1", 1, d[4]);
      cnt(300);
      chk("one", 1, k);
      chk("done", 1, done_irq_o);
      rd(`ACS_OFF_RES_HIGH);
      chk("high", V5[9:2], d);
      rd(`ACS_OFF_RES_LOW);
      chk("low", V5[1:0], d[7:6]);
      wr(`ACS_OFF_CTRL_A, 8'h15);
      rd(`ACS_OFF_CTRL_A);
      chk("bsy0", 8'h05, d[5:0]);
      wr(`ACS_OFF_IRQ_REQ, 8'h00);
      rd(`ACS_OFF_IRQ_REQ);
      chk("clr", 0, d[0]);
      $display("single done");
   endtask
   task t_chan;
      wr(`ACS_OFF_CTRL_B, 8'h02);
      rd(`ACS_OFF_CTRL_A);
      chk("mxa", 2, d[2:0]);
      wr(`ACS_OFF_CTRL_A, 8'h07);
      rd(`ACS_OFF_CTRL_B);
      chk("mxb", 7, d[2:0]);
      chk("sel", 8'h80, chan_sel_o);
      rd(8'h00);
      chk("unmp", 0, d);
      $display("chan done");
   endtask
   task t_cont;
      wr(`ACS_OFF_CTRL_A, 8'h0B);
      wr(`ACS_OFF_RES_LOW, 8'h5A);
      wsmp;
      wsmp;
      chk("per", `ACS_MCYC_DIV * `ACS_CONV_MCYC, k);
      rd(`ACS_OFF_PIN_IN);
      chk("pin", 8'hA5, d);
      wr(`ACS_OFF_CTRL_A, 8'h03);
      cnt(300);
      chk("last", 1, k);
      $display("cont done");
   endtask
   task t_ext;
      wr(`ACS_OFF_CTRL_A, 8'h21);
      cnt(40);
      ext_start_i <= 1'b0;
      cnt(300);
      chk("edge", 1, k);
      ext_start_i <= 1'b1;
      $display("ext done");
   endtask
   task final_report;
      $display("checked %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      arst_n_i = 1'b0; wr_i = 1'b0; rd_i = 1'b0; ext_start_i = 1'b1;
      addr_i = 8'h00; wdata_i = 8'h00; ain_dig_i = 8'hA5;
      cyc = 0; err_count = 0; samples_checked = 0;
      repeat (6) @(posedge sys_clk_i);
      arst_n_i <= 1'b1;
      t_extc;
      t_single;
      t_chan;
      t_cont;
      t_ext;
      final_report;
   end
endmodule // acs_sequencer_tb
